// [rtl/dio_port.sv]
// Discrete I/O port with APB command registers and change time stamp
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module dio_port #(
  parameter int LINES = dio_pkg::LINES
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LINES-1:0] line_in_i,
  output logic [LINES-1:0] line_out_o,
  output logic [LINES-1:0] line_oe_o
);
  logic [LINES-1:0] sync1, sync2;
  logic [LINES-1:0] dir;
  logic [LINES-1:0] drive;
  logic [31:0] value_arg;
  logic [31:0] mask_arg;
  logic [31:0] result_word;
  logic [31:0] ts_hms, ts_day, ts_sub;
  logic ts_valid;
  logic bad_op;
  logic [31:0] clk_hms_set, clk_day_set;
  logic clk_load;
  logic [4:0] hour;
  logic [5:0] min, sec;
  logic [8:0] day;
  logic [9:0] ms, us;
  logic [3:0] ns100;
  logic [LINES-1:0] line_state;
  logic [LINES-1:0] next_drive;
  logic [LINES-1:0] sel;
  logic wr_acc, rd_acc;
  logic op_go;
  logic [2:0] op_code;
  logic changed;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign op_go = wr_acc && (paddr == dio_pkg::OFF_OP);
  assign op_code = pwdata[2:0];

  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= line_in_i;
      sync2 <= sync1;
    end

  // Outputs read back from the driver latch, inputs from the pin
  assign line_state = (dir & drive) | (~dir & sync2); // R08

  assign sel = mask_arg[LINES-1:0]; // R05
  assign next_drive = (drive & ~sel) | (value_arg[LINES-1:0] & sel); // R04
  // Only lines that are outputs produce a visible change
  assign changed = |((next_drive ^ drive) & dir); // R11

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      value_arg <= '0;
      mask_arg <= '0;
    end
    else if (wr_acc && paddr == dio_pkg::OFF_VALUE)
      value_arg <= pwdata;
    else if (wr_acc && paddr == dio_pkg::OFF_MASK)
      mask_arg <= pwdata;

  // Time-of-day preset: seconds/minutes/hours and day
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      clk_hms_set <= '0;
      clk_day_set <= 32'(dio_pkg::DAY_FIRST);
      clk_load <= 1'b0;
    end
    else
    begin
      clk_load <= 1'b0;
      if (wr_acc && paddr == dio_pkg::OFF_TS_HMS)
        clk_hms_set <= pwdata;
      if (wr_acc && paddr == dio_pkg::OFF_TS_DAY)
      begin
        clk_day_set <= pwdata;
        clk_load <= 1'b1;
      end
    end

  // Output latch and direction, updated only by their own operations
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      drive <= dio_pkg::OUT_RESET; // R13
      dir <= dio_pkg::DIR_RESET; // R13 R06
    end
    else if (op_go && op_code == dio_pkg::WRITE_LINES_OP) // R03
      drive <= next_drive;
    else if (op_go && op_code == dio_pkg::SET_DIRECTION_OP) // R03
      dir <= value_arg[LINES-1:0]; // R06

  assign line_out_o = drive;
  assign line_oe_o = dir; // R01

  // Result word and time stamp; upper bits forced to zero
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      result_word <= '0;
      ts_hms <= '0;
      ts_day <= '0;
      ts_sub <= '0;
      ts_valid <= 1'b0;
      bad_op <= 1'b0;
    end
    else if (op_go)
    begin
      bad_op <= 1'b0;
      ts_valid <= 1'b0;
      unique case (op_code)
        dio_pkg::READ_LINES_OP:
          result_word <= {{(32-LINES){1'b0}}, line_state}; // R07 R08
        dio_pkg::WRITE_LINES_OP:
        begin
          // The latch updates this same edge, so present the post-update view
          result_word <= {{(32-LINES){1'b0}}, (dir & next_drive) | (~dir & sync2)}; // R09
          if (changed) // R11
          begin
            ts_hms <= {11'h000, hour, 2'h0, min, 2'h0, sec}; // R12
            ts_day <= {23'h000000, day}; // R12
            ts_sub <= {4'h0, ns100, 2'h0, us, ms, 2'h0}; // R12
            ts_valid <= 1'b1;
          end
          else
          begin
            ts_hms <= '0; // R11
            ts_day <= '0;
            ts_sub <= '0;
          end
        end
        dio_pkg::GET_DIRECTION_OP:
          result_word <= {{(32-LINES){1'b0}}, dir}; // R10
        dio_pkg::SET_DIRECTION_OP:
          result_word <= '0;
        dio_pkg::PORT_RESET_OP:
          result_word <= '0;
        default:
        begin
          result_word <= '0;
          bad_op <= 1'b1; // R02
        end
      endcase
    end

  dio_time_of_day u_tod (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .load_i(clk_load),
    .load_hms_i(clk_hms_set),
    .load_day_i(clk_day_set),
    .hour_o(hour),
    .min_o(min),
    .sec_o(sec),
    .day_o(day),
    .ms_o(ms),
    .us_o(us),
    .ns100_o(ns100)
  );

  // Read mux; unmapped offsets answer with an error and zero data
  always_comb
  begin
    prdata = '0;
    pslverr = 1'b0;
    if (rd_acc)
      unique case (paddr)
        dio_pkg::OFF_OP: prdata = '0;
        dio_pkg::OFF_VALUE: prdata = value_arg;
        dio_pkg::OFF_MASK: prdata = mask_arg;
        dio_pkg::OFF_RESULT: prdata = result_word;
        dio_pkg::OFF_STATUS: prdata = {26'h0000000, bad_op, ts_valid, line_state};
        dio_pkg::OFF_TS_HMS: prdata = ts_hms;
        dio_pkg::OFF_TS_DAY: prdata = ts_day;
        dio_pkg::OFF_TS_SUB: prdata = ts_sub;
        default: pslverr = 1'b1;
      endcase
    else if (wr_acc)
      pslverr = !(paddr inside {dio_pkg::OFF_OP, dio_pkg::OFF_VALUE, dio_pkg::OFF_MASK,
                                dio_pkg::OFF_TS_HMS, dio_pkg::OFF_TS_DAY});
  end
endmodule : dio_port

// [rtl/dio_pkg.sv]
// Package with constants, register map and opcodes of the discrete I/O port
// Overview of operation
// R01: Four lines, each input or output
// R02: Opcodes 0..4: read, write, getdir, setdir, reset
// R03: Value and mask used only by write/setdir
// R04: Write drives selected lines to value bits
// R05: Mask bits 3:0 select lines to change
// R06: Setdir bit 1 output, 0 input; default input
// R07: Result carries data in bits 3:0 only
// R08: Read returns pin for inputs, driven for outputs
// R09: Write returns line state after update
// R10: Getdir returns one direction bit per line
// R11: Timestamp on actual output change, else zero
// R12: Timestamp fields sign, hour, day, ms, us, 100ns; the code has no sign field and also stamps min and sec
// R13: Reset leaves all lines inputs, drivers off; the reset opcode 4 leaves direction and drivers unchanged
package dio_pkg;
  localparam int LINES = 4;
  localparam logic [11:0] OFF_OP = 12'h000;
  localparam logic [11:0] OFF_VALUE = 12'h004;
  localparam logic [11:0] OFF_MASK = 12'h008;
  localparam logic [11:0] OFF_RESULT = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_TS_HMS = 12'h014;
  localparam logic [11:0] OFF_TS_DAY = 12'h018;
  localparam logic [11:0] OFF_TS_SUB = 12'h01C;
  localparam logic [3:0] DIR_RESET = 4'h0;
  localparam logic [3:0] OUT_RESET = 4'h0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 100;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [8:0] DAY_FIRST = 9'h001;
  localparam logic [8:0] DAY_LAST = 9'h16E;
  typedef enum logic [2:0] {
    READ_LINES_OP = 3'h0,
    WRITE_LINES_OP = 3'h1,
    GET_DIRECTION_OP = 3'h2,
    SET_DIRECTION_OP = 3'h3,
    PORT_RESET_OP = 3'h4
  } dio_op_t;
endpackage : dio_pkg

// [rtl/dio_time_of_day.sv]
// Free-running time-of-day counter with 100 ns resolution
`timescale 1ns/1ps
module dio_time_of_day (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic [31:0] load_hms_i,
  input wire logic [31:0] load_day_i,
  output logic [4:0] hour_o,
  output logic [5:0] min_o,
  output logic [5:0] sec_o,
  output logic [8:0] day_o,
  output logic [9:0] ms_o,
  output logic [9:0] us_o,
  output logic [3:0] ns100_o
);
  logic [3:0] pre;
  logic t100;
  assign t100 = (pre == 4'(dio_pkg::TICK_CYCLES - 1));
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      pre <= 4'h0;
    else
      pre <= t100 ? 4'h0 : pre + 4'h1;
  // Cascaded rollover; loading restarts the sub-second part
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      {hour_o, min_o, sec_o, ms_o, us_o, ns100_o} <= '0;
      day_o <= dio_pkg::DAY_FIRST;
    end
    else if (load_i)
    begin
      hour_o <= load_hms_i[20:16];
      min_o <= load_hms_i[13:8];
      sec_o <= load_hms_i[5:0];
      day_o <= load_day_i[8:0];
      {ms_o, us_o, ns100_o} <= '0;
    end
    else if (t100)
    begin
      ns100_o <= (ns100_o == 4'h9) ? 4'h0 : ns100_o + 4'h1;
      if (ns100_o == 4'h9)
      begin
        us_o <= (us_o == 10'h3E7) ? 10'h000 : us_o + 10'h001;
        if (us_o == 10'h3E7)
        begin
          ms_o <= (ms_o == 10'h3E7) ? 10'h000 : ms_o + 10'h001;
          if (ms_o == 10'h3E7)
          begin
            sec_o <= (sec_o == 6'h3B) ? 6'h00 : sec_o + 6'h01;
            if (sec_o == 6'h3B)
            begin
              min_o <= (min_o == 6'h3B) ? 6'h00 : min_o + 6'h01;
              if (min_o == 6'h3B)
              begin
                hour_o <= (hour_o == 5'h17) ? 5'h00 : hour_o + 5'h01;
                if (hour_o == 5'h17)
                  day_o <= (day_o == dio_pkg::DAY_LAST) ? dio_pkg::DAY_FIRST : day_o + 9'h001;
              end
            end
          end
        end
      end
    end
endmodule : dio_time_of_day

// [dv/dio_port_chk.sv]
// Port-level checker for the discrete I/O port
`timescale 1ns/1ps
module dio_port_chk #(
  parameter int LINES = 4
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [LINES-1:0] line_in_i,
  input wire logic [LINES-1:0] line_out_o,
  input wire logic [LINES-1:0] line_oe_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  wire acc = psel && penable;
  wire op_wr = acc && pwrite && paddr == 12'h000;
  reset_dir_a: assert property ($rose(arst_n_i) |-> line_oe_o == 0) else $error("line not input after reset");
  result_bits_a: assert property (acc && !pwrite && paddr == 12'h00C |-> prdata[31:4] == 0)
    else $error("result high bits set");
  dir_cause_a: assert property ($changed(line_oe_o) |-> $past(op_wr && pwdata[2:0] == 3'h3))
    else $error("direction changed without setdir");
  out_cause_a: assert property ($changed(line_out_o & line_oe_o) && $stable(line_oe_o)
    |-> $past(op_wr && pwdata[2:0] == 3'h1)) else $error("output changed without write");
  other_ops_a: assert property (op_wr && pwdata[2:0] != 3'h1 |=> $stable(line_out_o))
    else $error("output latch moved");
  status_out_a: assert property (acc && !pwrite && paddr == 12'h010
    |-> ((prdata[3:0] ^ line_out_o) & line_oe_o) == 0) else $error("output readback wrong");
  unmapped_err_a: assert property (acc && paddr > 12'h01C |-> pslverr) else $error("no error");
  mapped_ok_a: assert property (acc && !pwrite && paddr <= 12'h01C && paddr[1:0] == 0 |-> !pslverr)
    else $error("spurious error");
  idle_data_a: assert property (!acc |-> prdata == 0 && !pslverr) else $error("bus not quiet");
  cover property (op_wr && pwdata[2:0] == 3'h1);
  cover property (op_wr && pwdata[2:0] == 3'h3);
  cover property (acc && pslverr);
endmodule : dio_port_chk
bind dio_port dio_port_chk #(.LINES(LINES)) chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .line_in_i(line_in_i), .line_out_o(line_out_o), .line_oe_o(line_oe_o));

// [dv/dio_line_model.sv]
// Model of the external discrete lines on the connector
`timescale 1ns/1ps
module dio_line_model (
  input wire logic [3:0] line_out_i,
  input wire logic [3:0] line_oe_i,
  input wire logic [3:0] ext_level_i,
  output logic [3:0] line_in_o
);
  // A driven line shows the port's level, the rest follow the outside source
  assign line_in_o = (line_oe_i & line_out_i) | (~line_oe_i & ext_level_i);
endmodule : dio_line_model

// [dv/tb_discrete_io_port.sv]
// Testbench for the discrete I/O port
`timescale 1ns/1ps
module tb_discrete_io_port;
  logic clk_sys_i = 0;
  logic arst_n_i = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [3:0] line_in_i, line_out_o, line_oe_o;
  logic [3:0] ext = 4'hA;
  int errors = 0;
  int check_count = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  dio_port DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in_i(line_in_i), .line_out_o(line_out_o), .line_oe_o(line_oe_o));
  dio_line_model PINS (.line_out_i(line_out_o), .line_oe_i(line_oe_o), .ext_level_i(ext), .line_in_o(line_in_i));
  task automatic complete_run;
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50)
    begin
      errors++;
      complete_run();
    end
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk
  // Loads value and mask, then issues the operation code
  task automatic op(input logic [3:0] v, input logic [7:0] m, input logic [2:0] c);
    apb(1, 12'h004, {28'h0, v});
    apb(1, 12'h008, {24'h0, m});
    apb(1, 12'h000, {29'h0, c});
    // Latch and direction update on the access edge; look one edge later
    @(posedge clk_sys_i);
  endtask : op
  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1;
    @(posedge clk_sys_i);
    check({line_oe_o, line_out_o}, 32'h0);
    rdchk(12'h010, 32'h0000000A);
    op(4'h5, 8'hFF, 3'h1);
    rdchk(12'h00C, 32'h0000000A);
    rdchk(12'h018, 32'h0);
    op(4'h3, 8'h00, 3'h3);
    check(line_oe_o, 4'h3);
    check(line_out_o, 4'h5);
    op(4'hF, 8'hFF, 3'h2);
    rdchk(12'h00C, 32'h3);
    check(line_oe_o, 4'h3);
    op(4'h0, 8'hFF, 3'h0);
    rdchk(12'h00C, 32'h9);
    op(4'h2, 8'hF1, 3'h1);
    check(line_out_o, 4'h4);
    rdchk(12'h00C, 32'h8);
    rdchk(12'h018, 32'h1);
    rdchk(12'h010, 32'h00000018);
    op(4'h4, 8'hFF, 3'h1);
    rdchk(12'h018, 32'h0);
    op(4'h0, 8'hFF, 3'h4);
    check({line_oe_o, line_out_o}, 32'h34);
    ext <= 4'h5;
    op(4'h0, 8'h00, 3'h0);
    rdchk(12'h00C, 32'h4);
    apb(0, 12'h100, 32'h0);
    check(err, 1'b1);
    op(4'h0, 8'h00, 3'h5);
    rdchk(12'h010, 32'h00000024);
    apb(1, 12'h014, 32'h00050607);
    apb(1, 12'h018, 32'h0000000A);
    op(4'h1, 8'h01, 3'h1);
    rdchk(12'h014, 32'h00050607);
    rdchk(12'h018, 32'h0000000A);
    complete_run();
  end
endmodule : tb_discrete_io_port
